// File: bench/stc_sys_model.sv
// System reset logic outside the device: drives reset and the three straps.
// Assumes the bench calls run_reset at a falling edge and leaves these alone.
`timescale 1ns/1ps
`default_nettype none

module stc_sys_model (
  // Clock
  input  wire logic sys_clk,
  // Reset and straps
  output logic      reset,
  output logic      addr_hold_in,
  output logic      cache_invalidate_n,
  output logic      addr_bit20_mask_in_n
);
  initial
  begin
    reset = 1'b1;
    addr_hold_in = 1'b0;
    cache_invalidate_n = 1'b1;
    addr_bit20_mask_in_n = 1'b1;
  end

  // Strap levels at reset fall: bit 2 hold, bit 1 invalidate_n, bit 0 mask_n
  task automatic run_reset(input logic [2:0] st);
    @(negedge sys_clk);
    reset = 1'b1;
    repeat (15) @(negedge sys_clk);
    addr_hold_in = st[2];
    cache_invalidate_n = st[1];
    addr_bit20_mask_in_n = st[0];
    @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    // Straps return to idle once sampled; invalidate stays high in test
    addr_hold_in = 1'b0;
    cache_invalidate_n = 1'b1;
    addr_bit20_mask_in_n = 1'b1;
  endtask : run_reset
endmodule : stc_sys_model

`default_nettype wire

// File: bench/stc_top_test.sv
// Self-checking bench for the self-test entry and cache test port.
// Assumes the design files and the system model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module stc_top_test;
  import stc_pkg::*;
  // Shortened self-test length keeps the run brief
  localparam int unsigned BIST_N = 4096;
  typedef struct packed {
    logic [6:0]   set;
    logic [1:0]   way;
    logic [20:0]  tag;
    logic         vld;
    logic [127:0] data;
  } stc_row_t;

  logic        sys_clk;
  logic        reset;
  logic        addr_hold_in;
  logic        cache_invalidate_n;
  logic        addr_bit20_mask_in_n;
  logic        treg_wr;
  logic        treg_rd;
  stc_treg_t   treg_sel;
  logic [31:0] treg_wdata;
  logic [31:0] treg_rdata;
  logic        bus_cycle_allow;
  logic        bist_active;
  logic [31:0] accum_result;
  int          err_count;
  int          checked;
  logic [31:0] rv;
  stc_row_t    rows [4];

  stc_sys_model i_sys (
    .sys_clk              (sys_clk),
    .reset                (reset),
    .addr_hold_in         (addr_hold_in),
    .cache_invalidate_n   (cache_invalidate_n),
    .addr_bit20_mask_in_n (addr_bit20_mask_in_n)
  );

  stc_top #(.BIST_CYCLES(BIST_N)) i_dut (
    .sys_clk              (sys_clk),
    .reset                (reset),
    .addr_hold_in         (addr_hold_in),
    .cache_invalidate_n   (cache_invalidate_n),
    .addr_bit20_mask_in_n (addr_bit20_mask_in_n),
    .treg_wr              (treg_wr),
    .treg_rd              (treg_rd),
    .treg_sel             (treg_sel),
    .treg_wdata           (treg_wdata),
    .treg_rdata           (treg_rdata),
    .bus_cycle_allow      (bus_cycle_allow),
    .bist_active          (bist_active),
    .accum_result         (accum_result)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Accesses start and end at a falling edge, one idle cycle between them
  task automatic wr(input stc_treg_t sel, input logic [31:0] d);
    treg_wr = 1'b1;
    treg_sel = sel;
    treg_wdata = d;
    @(negedge sys_clk);
    treg_wr = 1'b0;
    @(negedge sys_clk);
  endtask : wr

  task automatic rd(input stc_treg_t sel);
    treg_rd = 1'b1;
    treg_sel = sel;
    @(negedge sys_clk);
    treg_rd = 1'b0;
    rv = treg_rdata;
    @(negedge sys_clk);
  endtask : rd

  task automatic wait_allow(input int lim);
    int n;
    n = 0;
    while (bus_cycle_allow !== 1'b1 && n < lim)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (bus_cycle_allow !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: bus never released", $time);
      results();
    end
  endtask : wait_allow

  task automatic read_entry(input logic [6:0] set, input logic [1:0] way);
    wr(STC_TREG_CMD, {21'h0, set, way, 2'b10});
    // Read buffer and status settle two edges after the command
    repeat (2) @(negedge sys_clk);
    rd(STC_TREG_STATUS);
  endtask : read_entry

  initial
  begin
    int n;
    int act;
    int last;
    logic [2:0] skip_st [3];
    treg_wr = 1'b0;
    treg_rd = 1'b0;
    treg_sel = STC_TREG_NONE;
    treg_wdata = 32'h0000_0000;
    err_count = 0;
    checked = 0;
    rows[0] = {7'h00, 2'h0, 21'h1a2b3c, 1'b1, 128'h0f1e2d3c_4b5a6978_8796a5b4_c3d2e1f0};
    rows[1] = {7'h7f, 2'h3, 21'h1fffff, 1'b1, 128'hffff0000_0000ffff_aaaa5555_5555aaaa};
    rows[2] = {7'h05, 2'h1, 21'h000001, 1'b0, 128'h01234567_89abcdef_fedcba98_76543210};
    rows[3] = {7'h7f, 2'h2, 21'h0a5a5a, 1'b1, 128'hdeadbeef_cafef00d_00000001_80000000};
    skip_st[0] = 3'b011;
    skip_st[1] = 3'b111;
    skip_st[2] = 3'b100;
    i_sys.run_reset(3'b011);
    wait_allow(12);
    // Cache taken as disabled and replace-off here
    for (int r = 0; r < 4; r++)
    begin
      for (int w = 0; w < 4; w++)
      begin
        wr(STC_TREG_CMD, 32'(w) << 2);
        wr(STC_TREG_DATA, rows[r].data[32*w +: 32]);
      end
      wr(STC_TREG_STATUS, {rows[r].tag, rows[r].vld, 10'h000});
      wr(STC_TREG_CMD, {21'h0, rows[r].set, rows[r].way, 2'b01});
      read_entry(rows[r].set, rows[r].way);
      chk(rv & 32'hffff_fc07, {rows[r].tag, rows[r].vld, 10'h000});
      chk(32'(rv[3 + rows[r].way]), 32'(rows[r].vld));
      for (int w = 0; w < 4; w++)
      begin
        wr(STC_TREG_CMD, 32'(w) << 2);
        rd(STC_TREG_DATA);
        chk(rv, rows[r].data[32*w +: 32]);
      end
    end
    // Flush clears valid and LRU state but keeps tag and data
    wr(STC_TREG_CMD, 32'h0000_07ff);
    rd(STC_TREG_CMD);
    chk(rv, 32'h0000_07ff);
    read_entry(7'h00, 2'h0);
    chk(rv, {rows[0].tag, 1'b0, 10'h000});
    wr(STC_TREG_CMD, 32'h0000_0000);
    rd(STC_TREG_DATA);
    chk(rv, rows[0].data[31:0]);
    // Data window is closed while control is not 00
    wr(STC_TREG_CMD, 32'h0000_0003);
    wr(STC_TREG_DATA, 32'h1234_5678);
    rd(STC_TREG_DATA);
    chk(rv, 32'h0000_0000);
    wr(STC_TREG_CMD, 32'h0000_0000);
    rd(STC_TREG_DATA);
    chk(rv, rows[0].data[31:0]);
    for (int s = 0; s < 3; s++)
    begin
      i_sys.run_reset(skip_st[s]);
      chk(32'(bist_active), 32'h0000_0000);
      // Writes before the bus is released must be ignored
      wr(STC_TREG_CMD, 32'h0000_07fc);
      wait_allow(12);
      rd(STC_TREG_CMD);
      chk(rv, 32'h0000_0000);
    end
    i_sys.run_reset(3'b101);
    chk(32'(bist_active), 32'h0000_0001);
    n = 0;
    act = 1;
    last = 0;
    while (bus_cycle_allow !== 1'b1 && n < BIST_N + 200)
    begin
      @(negedge sys_clk);
      n++;
      if (bist_active === 1'b1)
      begin
        act++;
        last = n;
      end
    end
    chk(32'(bus_cycle_allow), 32'h0000_0001);
    chk(32'(act >= BIST_N - 16 && act <= BIST_N + 16), 32'h1);
    chk(32'(n - last <= 10), 32'h0000_0001);
    chk(accum_result, 32'h0000_0000);
    // Last self-test command stays: test write of set 7f, entry 3
    rd(STC_TREG_CMD);
    chk(rv, 32'h0000_07fd);
    results();
  end
endmodule : stc_top_test

`default_nettype wire

// File: src/stc_cache_array.sv
// Cache arrays: 128 sets of four ways, 128-bit lines, 21-bit tags,
// per-set valid and pseudo-LRU bits. Driven through the cache interface.
`timescale 1ns/1ps
`default_nettype none
`include "stc_consts.svh"

module stc_cache_array (
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   reset,
  // Requests from the test port
  stc_cache_if.array  cif
);
  import stc_pkg::*;

  logic [127:0] data_mem [0:511];
  logic [20:0]  tag_mem  [0:511];
  logic [3:0]   valid_q  [0:127];
  logic [2:0]   lru_q    [0:127];
  logic [8:0]   idx;
  logic         do_wr;
  logic         do_rd;
  logic         do_fl;

  assign idx   = {cif.set, cif.way};
  assign do_wr = cif.op_valid && (cif.op == STC_OP_WRITE);
  assign do_rd = cif.op_valid && (cif.op == STC_OP_READ);
  assign do_fl = cif.op_valid && (cif.op == STC_OP_FLUSH);

  function automatic logic [2:0] stc_lru_next(input logic [2:0] l,
                                              input logic [1:0] w);
    logic [2:0] n;
    n    = l;
    n[0] = ~w[1];
    if (!w[1])
      n[1] = ~w[0];
    else
      n[2] = ~w[0];
    return n;
  endfunction : stc_lru_next

  // Tag and data arrays keep their contents across a flush
  always_ff @(posedge sys_clk)
  begin
    if (do_wr)
    begin
      data_mem[idx] <= cif.wdata;
      tag_mem[idx]  <= cif.wtag;
    end
  end

  genvar s;
  generate
    for (s = 0; s < 128; s++)
    begin : g_set
      logic sel;
      assign sel = (cif.set == 7'(s));
      always_ff @(posedge sys_clk or posedge reset)
      begin
        if (reset)
        begin
          valid_q[s] <= 4'h0;
          lru_q[s]   <= 3'h0;
        end
        else if (do_fl)
        begin
          valid_q[s] <= 4'h0;
          lru_q[s]   <= 3'h0;
        end
        else if (do_wr && sel)
        begin
          valid_q[s][cif.way] <= cif.wvalid;
          lru_q[s]            <= stc_lru_next(lru_q[s], cif.way);
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      cif.rdata     <= 128'h0;
      cif.rtag      <= 21'h0;
      cif.rvalid    <= 1'b0;
      cif.rlru      <= 3'h0;
      cif.rsetvalid <= 4'h0;
    end
    else if (do_rd)
    begin
      cif.rdata     <= data_mem[idx];
      cif.rtag      <= tag_mem[idx];
      cif.rvalid    <= valid_q[cif.set][cif.way];
      cif.rlru      <= lru_q[cif.set];
      cif.rsetvalid <= valid_q[cif.set];
    end
  end

  a_flush_clears: assert property (@(posedge sys_clk) disable iff (reset)
    do_fl |=> (valid_q[$past(cif.set)] == 4'h0)
              && (lru_q[$past(cif.set)] == 3'h0))
    else $error("flush left valid or LRU bits set");

  a_write_stores: assert property (@(posedge sys_clk) disable iff (reset)
    do_wr |=> data_mem[$past(idx)] == $past(cif.wdata)
              && valid_q[$past(cif.set)][$past(cif.way)]
                 == $past(cif.wvalid))
    else $error("test write did not store line and valid");

endmodule : stc_cache_array

`default_nettype wire

// File: src/stc_cache_if.sv
// Request and answer lines between the test port and the cache arrays.
// Assumes one clock; answers to a read appear one edge after the request.
`timescale 1ns/1ps
`default_nettype none

interface stc_cache_if;
  import stc_pkg::*;
  logic          op_valid;
  stc_op_t       op;
  logic [6:0]    set;
  logic [1:0]    way;
  logic [127:0]  wdata;
  logic [20:0]   wtag;
  logic          wvalid;
  logic [127:0]  rdata;
  logic [20:0]   rtag;
  logic          rvalid;
  logic [2:0]    rlru;
  logic [3:0]    rsetvalid;

  modport master (output op_valid, op, set, way, wdata, wtag, wvalid,
                  input rdata, rtag, rvalid, rlru, rsetvalid);
  modport array  (input op_valid, op, set, way, wdata, wtag, wvalid,
                  output rdata, rtag, rvalid, rlru, rsetvalid);
endinterface : stc_cache_if

`default_nettype wire

// File: src/stc_consts.svh
// Offsets, field positions, reset values and counts of the self-test
// entry and cache test port; included by the cache array and top design files only.
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH

// Command register fields
`define STC_CTRL_LSB      0
`define STC_ENTRY_LSB     2
`define STC_SET_LSB       4
`define STC_SET_MSB       10
// Tag/status register fields and both reset values
`define STC_TAG_LSB       11
`define STC_VALID_BIT     10
`define STC_LRU_LSB       7
`define STC_SETV_LSB      3
`define STC_STATUS_RESET  32'h0000_0000
`define STC_CMD_RESET     32'h0000_0000
// Self-test figures
`define STC_BIST_CYCLES   1048576
`define STC_RESEQ_CYCLES  8
`define STC_BIST_PAT      32'ha5c3_5a3c
`define STC_LAST_ENTRY    9'h1ff

`endif

// File: src/stc_pkg.sv
// Types shared by the self-test and cache test port modules.
// Assumes the constants header is compiled alongside.
package stc_pkg;

  typedef enum logic [1:0] {
    STC_OP_BUF,
    STC_OP_WRITE,
    STC_OP_READ,
    STC_OP_FLUSH
  } stc_op_t;

  typedef enum logic [1:0] {
    STC_TREG_DATA,
    STC_TREG_STATUS,
    STC_TREG_CMD,
    STC_TREG_NONE
  } stc_treg_t;

  typedef enum logic [2:0] {
    S_CHECK,
    S_BIST_WR,
    S_BIST_RD,
    S_BIST_CMP,
    S_WAIT,
    S_RESEQ,
    S_RUN
  } stc_state_t;

endpackage : stc_pkg

// File: src/stc_top.sv
// Self-test entry and cache test port: strap check, built-in cache test,
// result in the accumulator, and the three cache test registers.
// Assumes straps and register strobes are synchronous to sys_clk.
//
// What this block does
// - Self test lasts about two to the twentieth clocks, counted here
// - No external bus cycle starts until the self test ends
// - Result left in accumulator: zero passes, nonzero flags a flaw
// - After the test, run reset sequence then normal operation unaided
// - Test writes, reads back and compares all 512 cache entries
// - Self test overwrites the cache test registers
// - 128-bit fill buffer feeds writes; 128-bit read buffer receives reads
// - Data window is the only buffer path; entry select picks the word
// - After test read, status holds tag, valid, LRU and set valid bits
// - Seven-bit set select picks a set, ignored for buffer and flush
// - Entry select means buffer word or way depending on control
// - Control 00 buffer, 01 write, 10 read, 11 flush
// - With control 00, a data window write fills the selected word
// - Control 01 copies fill buffer and tag into the entry, updates LRU
// - Control 11 clears LRU and valid bits, keeps tags and data
// - Control 10 loads status and the read buffer from the entry
`timescale 1ns/1ps
`default_nettype none
`include "stc_consts.svh"

module stc_top #(
  parameter int unsigned BIST_CYCLES = `STC_BIST_CYCLES
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // Self-test straps
  input  wire logic               addr_hold_in,
  input  wire logic               cache_invalidate_n,
  input  wire logic               addr_bit20_mask_in_n,
  // Test register port
  input  wire logic               treg_wr,
  input  wire logic               treg_rd,
  input  wire stc_pkg::stc_treg_t treg_sel,
  input  wire logic [31:0]        treg_wdata,
  output logic [31:0]             treg_rdata,
  // Core status
  output logic                    bus_cycle_allow,
  output logic                    bist_active,
  output logic [31:0]             accum_result
);
  import stc_pkg::*;

  stc_cache_if cif ();

  stc_cache_array u_array (
    .sys_clk (sys_clk),
    .reset   (reset),
    .cif     (cif)
  );

  stc_state_t   state_q, state_d;
  logic [20:0]  cnt_q, cnt_d;
  logic [8:0]   idx_q, idx_d;
  logic         pass_q, pass_d;
  logic [31:0]  err_q, err_d;
  logic [3:0]   reseq_q, reseq_d;
  logic [127:0] fill_q, fill_d;
  logic [127:0] rbuf_q, rbuf_d;
  logic [31:0]  status_q, status_d;
  logic [31:0]  cmd_q, cmd_d;
  logic         rd_pend_q, rd_pend_d;
  logic [31:0]  rdata_q, rdata_d;

  logic         sw_ok;
  logic         cmd_wr;
  stc_op_t      wop;
  stc_op_t      cur_op;
  logic [1:0]   cur_entry;
  logic         entry_ok;
  logic [31:0]  pat;
  logic [20:0]  pat_tag;
  logic         mismatch;
  logic [31:0]  rbuf_word;

  assign sw_ok     = (state_q == S_RUN);
  assign cmd_wr    = treg_wr && sw_ok && (treg_sel == STC_TREG_CMD);
  assign wop       = stc_op_t'(treg_wdata[`STC_CTRL_LSB +: 2]);
  assign cur_op    = stc_op_t'(cmd_q[`STC_CTRL_LSB +: 2]);
  assign cur_entry = cmd_q[`STC_ENTRY_LSB +: 2];
  assign entry_ok  = addr_hold_in && !cache_invalidate_n
                     && addr_bit20_mask_in_n;
  // Pattern differs per entry and per pass so stuck bits show
  assign pat       = `STC_BIST_PAT ^ {23'h0, idx_q} ^ {32{pass_q}};
  assign pat_tag   = {12'h0, idx_q} ^ {21{pass_q}};
  assign mismatch  = (cif.rdata != {4{pat}}) || (cif.rtag != pat_tag)
                     || !cif.rvalid;
  assign rbuf_word = rbuf_q[32*cur_entry +: 32];

  // Requests toward the arrays
  always_comb
  begin
    cif.op_valid = 1'b0;
    cif.op       = STC_OP_BUF;
    cif.set      = treg_wdata[`STC_SET_MSB:`STC_SET_LSB];
    cif.way      = treg_wdata[`STC_ENTRY_LSB +: 2];
    cif.wdata    = fill_q;
    cif.wtag     = status_q[31:`STC_TAG_LSB];
    cif.wvalid   = status_q[`STC_VALID_BIT];
    case (state_q)
      S_BIST_WR, S_BIST_RD:
      begin
        cif.op_valid = 1'b1;
        cif.op       = (state_q == S_BIST_WR) ? STC_OP_WRITE : STC_OP_READ;
        cif.set      = idx_q[8:2];
        cif.way      = idx_q[1:0];
        cif.wdata    = {4{pat}};
        cif.wtag     = pat_tag;
        cif.wvalid   = 1'b1;
      end
      S_RESEQ:
      begin
        cif.op_valid = (reseq_q == 4'h0);
        cif.op       = STC_OP_FLUSH;
      end
      S_RUN:
      begin
        cif.op_valid = cmd_wr && (wop != STC_OP_BUF);
        cif.op       = wop;
      end
      default:
      begin
        cif.op_valid = 1'b0;
      end
    endcase
  end

  // Sequencer: strap check, self test, reset sequence, run
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    idx_d   = idx_q;
    pass_d  = pass_q;
    err_d   = err_q;
    reseq_d = reseq_q;
    if (state_q inside {S_BIST_WR, S_BIST_RD, S_BIST_CMP, S_WAIT})
      cnt_d = cnt_q + 21'h1;
    case (state_q)
      S_CHECK:
        state_d = entry_ok ? S_BIST_WR : S_RESEQ;
      S_BIST_WR:
      begin
        idx_d = idx_q + 9'h1;
        if (idx_q == `STC_LAST_ENTRY)
          state_d = S_BIST_RD;
      end
      S_BIST_RD:
        state_d = S_BIST_CMP;
      S_BIST_CMP:
      begin
        if (mismatch && (err_q == 32'h0))
          err_d = {1'b1, 22'h0, idx_q};
        idx_d   = idx_q + 9'h1;
        state_d = S_BIST_RD;
        if (idx_q == `STC_LAST_ENTRY)
        begin
          pass_d  = 1'b1;
          state_d = pass_q ? S_WAIT : S_BIST_WR;
        end
      end
      S_WAIT:
        if (cnt_q >= 21'(BIST_CYCLES - 1))
          state_d = S_RESEQ;
      S_RESEQ:
      begin
        reseq_d = reseq_q + 4'h1;
        if (reseq_q == 4'(`STC_RESEQ_CYCLES - 1))
          state_d = S_RUN;
      end
      S_RUN:
        state_d = S_RUN;
      default:
        state_d = S_CHECK;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= S_CHECK;
      cnt_q   <= 21'h0;
      idx_q   <= 9'h0;
      pass_q  <= 1'b0;
      err_q   <= 32'h0;
      reseq_q <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      idx_q   <= idx_d;
      pass_q  <= pass_d;
      err_q   <= err_d;
      reseq_q <= reseq_d;
    end
  end

  // Test registers and buffers
  always_comb
  begin
    fill_d    = fill_q;
    rbuf_d    = rbuf_q;
    status_d  = status_q;
    cmd_d     = cmd_q;
    rd_pend_d = cif.op_valid && (cif.op == STC_OP_READ);
    rdata_d   = rdata_q;
    if (state_q == S_BIST_WR)
    begin
      fill_d = {4{pat}};
      status_d[31:`STC_VALID_BIT] = {pat_tag, 1'b1};
      cmd_d  = {21'h0, idx_q, 2'(STC_OP_WRITE)};
    end
    if (rd_pend_q)
    begin
      rbuf_d   = cif.rdata;
      status_d = {cif.rtag, cif.rvalid, cif.rlru, cif.rsetvalid,
                  3'h0};
    end
    if (treg_wr && sw_ok)
    begin
      case (treg_sel)
        STC_TREG_DATA:
          if (cur_op == STC_OP_BUF)
            fill_d[32*cur_entry +: 32] = treg_wdata;
        STC_TREG_STATUS:
          status_d = {treg_wdata[31:`STC_VALID_BIT], status_q[9:0]};
        STC_TREG_CMD:
          cmd_d = {21'h0, treg_wdata[`STC_SET_MSB:0]};
        default:
          cmd_d = cmd_q;
      endcase
    end
    if (treg_rd)
    begin
      case (treg_sel)
        STC_TREG_DATA:
          rdata_d = (cur_op == STC_OP_BUF) ?
                    rbuf_q[32*cur_entry +: 32] : 32'h0;
        STC_TREG_STATUS:
          rdata_d = status_q;
        STC_TREG_CMD:
          rdata_d = cmd_q;
        default:
          rdata_d = 32'h0;
      endcase
      if (!sw_ok)
        rdata_d = 32'h0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      fill_q    <= 128'h0;
      rbuf_q    <= 128'h0;
      status_q  <= `STC_STATUS_RESET;
      cmd_q     <= `STC_CMD_RESET;
      rd_pend_q <= 1'b0;
      rdata_q   <= 32'h0;
    end
    else
    begin
      fill_q    <= fill_d;
      rbuf_q    <= rbuf_d;
      status_q  <= status_d;
      cmd_q     <= cmd_d;
      rd_pend_q <= rd_pend_d;
      rdata_q   <= rdata_d;
    end
  end

  assign treg_rdata      = rdata_q;
  assign accum_result    = err_q;
  assign bus_cycle_allow = (state_q == S_RUN);
  assign bist_active     = state_q inside {S_BIST_WR, S_BIST_RD,
                                           S_BIST_CMP, S_WAIT};

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  a_no_bus_test: assert property (
    bist_active |-> !bus_cycle_allow ##1 !bus_cycle_allow)
    else $error("bus allowed during self test");
  a_bist_wait_hold: assert property (
    (state_q == S_WAIT) && (cnt_q < 21'(BIST_CYCLES - 1))
    |=> state_q == S_WAIT)
    else $error("self test ended before its cycle count");
  a_bist_wait_end: assert property (
    (state_q == S_WAIT) && (cnt_q == 21'(BIST_CYCLES - 1))
    |=> state_q == S_RESEQ)
    else $error("self test overran its cycle count");
  a_reseq_to_run: assert property (
    (state_q == S_RESEQ) && (reseq_q == 4'(`STC_RESEQ_CYCLES - 1))
    |=> bus_cycle_allow)
    else $error("normal operation did not follow reset sequence");
  a_skip_test: assert property (
    (state_q == S_CHECK) && !entry_ok |=> state_q == S_RESEQ
    ##1 !bist_active)
    else $error("self test entered without straps");
  a_fail_nonzero: assert property (
    (state_q == S_BIST_CMP) && mismatch |=> accum_result != 32'h0)
    else $error("compare failure not recorded");
  a_fill_word: assert property (
    treg_wr && sw_ok && (treg_sel == STC_TREG_DATA) && (cur_op == STC_OP_BUF)
    |=> fill_q[32*$past(cur_entry) +: 32] == $past(treg_wdata))
    else $error("fill buffer word not loaded");
  a_rbuf_word: assert property (
    treg_rd && sw_ok && (treg_sel == STC_TREG_DATA) && (cur_op == STC_OP_BUF)
    |=> treg_rdata == $past(rbuf_word))
    else $error("data window read returned wrong word");
  a_read_status: assert property (
    cmd_wr && (wop == STC_OP_READ) |=> rd_pend_q
    ##1 status_q[`STC_VALID_BIT] == $past(cif.rvalid))
    else $error("test read did not load status");

  c_bist_pass: cover property (
    (state_q == S_WAIT) ##1 (state_q == S_RESEQ) && (err_q == 32'h0));
  c_cache_read: cover property (cmd_wr && (wop == STC_OP_READ));
  c_flush: cover property (cmd_wr && (wop == STC_OP_FLUSH));
  c_skip: cover property ((state_q == S_CHECK) && !entry_ok);

endmodule : stc_top

`default_nettype wire
